// File: logic/sbg_params.svh
`ifndef SBG_PARAMS_SVH
`define SBG_PARAMS_SVH
// register offsets on the plain register port
`define SBG_OFF_STC 3'h0
`define SBG_OFF_RELOAD 3'h1
`define SBG_OFF_MODE 3'h2
`define SBG_OFF_WAIT 3'h3
`define SBG_OFF_STATUS 3'h4
`define SBG_OFF_COUNT 3'h5
// reset values
`define SBG_RST_STC 8'h00
`define SBG_RST_RELOAD 8'h00
`define SBG_RST_MODE 8'h00
`define SBG_RST_WAIT 8'h00
`define SBG_RD_ZERO 8'h00
// serial/timer control fields
`define SBG_STC_TWOWIRE_HI 7
`define SBG_STC_TWOWIRE_LO 4
`define SBG_STC_HOST_SW 3
`define SBG_STC_MPE 2
`define SBG_STC_TMR_HI 1
`define SBG_STC_TMR_LO 0
// serial mode fields
`define SBG_MODE_SYNC 7
`define SBG_MODE_MP 2
`define SBG_MODE_SEL_HI 1
`define SBG_MODE_SEL_LO 0
// wait-state control fields
`define SBG_WAIT_DBL 0
`define SBG_WAIT_PHALF 1
// status fields
`define SBG_ST_SCLK 0
`define SBG_ST_NOCONT 1
`define SBG_ST_RUN 2
// prescaler masks: count length minus one
`define SBG_MASK_D1 7'h00
`define SBG_MASK_D4 7'h03
`define SBG_MASK_D8 7'h07
`define SBG_MASK_D16 7'h0F
`define SBG_MASK_D32 7'h1F
`define SBG_MASK_D64 7'h3F
`define SBG_MASK_D128 7'h7F
`endif

// File: logic/sbg_pkg.sv
package sbg_pkg;
  // run control of the internal serial clock
  typedef enum logic [1:0] {
    run_idle,
    run_arm,
    run_active
  } sbg_run_type;
  typedef logic [1:0] sbg_sel_type;
endpackage

// File: logic/sbg_prescaler.sv
`timescale 1ns/100ps
`include "sbg_params.svh"
module sbg_prescaler
  import sbg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic base_en,
  input wire sbg_sel_type sel,
  input wire logic dbl,
  // prescaled pulse
  output logic tick
);
  logic [6:0] cnt_r;
  logic [6:0] mask;

  // division length from selector and doubling bit
  always_comb begin
    case ({dbl, sel})
      3'h0: mask = `SBG_MASK_D1;
      3'h1: mask = `SBG_MASK_D4;
      3'h2: mask = `SBG_MASK_D16;
      3'h3: mask = `SBG_MASK_D64;
      3'h4: mask = `SBG_MASK_D1;
      3'h5: mask = `SBG_MASK_D8;
      3'h6: mask = `SBG_MASK_D32;
      default: mask = `SBG_MASK_D128;
    endcase
  end

  // free counter of base pulses; clr realigns it when the clock starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else if (clr) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else begin
      tick <= base_en && ((cnt_r & mask) == mask);
      if (base_en) begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end
endmodule // sbg_prescaler

// File: logic/sbg_divider.sv
`timescale 1ns/100ps
`include "sbg_params.svh"
module sbg_divider #(
  parameter int RELOAD_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic restart,
  input wire logic tick,
  input wire logic [RELOAD_W-1:0] reload,
  // terminal count pulse and live count
  output logic tc,
  output logic [RELOAD_W-1:0] count
);
  // count down prescaled pulses, reload from N: one tc per N+1 ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      tc <= 1'b0;
    end else if (restart) begin
      count <= reload;
      tc <= 1'b0;
    end else begin
      tc <= 1'b0;
      if (tick) begin
        if (count == '0) begin
          count <= reload;
          tc <= 1'b1;
        end else begin
          count <= count - RELOAD_W'(1);
        end
      end
    end
  end
endmodule // sbg_divider

// File: logic/sbg_top.sv
// Functional notes
// - undoubled prescale: source clock divided by 1, 4, 16, 64 for selector 0-3
// - doubled prescale: source clock divided by 1, 8, 32, 128 for selector 0-3
// - bit period is four times the prescale division above times N+1 source clocks
// - reload value N is an 8-bit register, 0 to 255
// - serial/timer control is 8 bits, all read/write, reset to zero
// - multiprocessor enable clear disables multiprocessor mode whatever the format bit
// - multiprocessor enable set enables it on serial channels 0 and 1
// - control bits 7 to 4 go to the two-wire bus interface
// - control bit 3 goes to the host interface input selection
// - control bits 1 and 0 go to the 8-bit timer clock selection
`timescale 1ns/100ps
`include "sbg_params.svh"
module sbg_top
  import sbg_pkg::*;
#(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // format bit of the second serial channel
  input wire logic ch1_multiproc_format_bit,
  // serial clock pin, output only in internal clock mode
  output logic sclk_out,
  output logic sclk_oe,
  // bit timing pulses for the shift logic
  output logic bit_shift,
  output logic bit_sample,
  // multiprocessor function per channel
  output logic [1:0] multiproc_enable,
  output logic [1:0] multiproc_active,
  // forwarded control fields
  output logic [3:0] twowire_ctrl,
  output logic host_input_switch,
  output logic [1:0] timer_clk_sel
);
  localparam int NCH = 2;

  // registers
  logic [DATA_W-1:0] serial_timer_control_r;
  logic [7:0] bit_rate_reload_r;
  logic [DATA_W-1:0] serial_mode_reg_r;
  logic [DATA_W-1:0] wait_state_ctrl_reg_r;
  logic [DATA_W-1:0] reg_rdata_nxt;

  // decoded strobes
  logic wr_stc;
  logic wr_reload;
  logic wr_mode;
  logic wr_wait;

  // control fields
  sbg_sel_type prescale_sel;
  logic clock_double_sel;
  logic periph_half;
  logic sync_en;
  logic multiproc_format_bit;
  logic no_continuous;

  // clock generation state
  sbg_run_type run_r;
  sbg_run_type run_nxt;
  logic pclk_phase_r;
  logic pclk_en;
  logic base_en;
  logic pre_tick;
  logic div_tc;
  logic [7:0] div_count;
  logic half_r;
  logic sclk_r;
  logic restart;
  logic prescale_clr;
  logic [NCH-1:0] mp_bits;

  // address decode; only one strobe is ever high at a time
  assign wr_stc = reg_wr && (reg_addr == `SBG_OFF_STC);
  assign wr_reload = reg_wr && (reg_addr == `SBG_OFF_RELOAD);
  assign wr_mode = reg_wr && (reg_addr == `SBG_OFF_MODE);
  assign wr_wait = reg_wr && (reg_addr == `SBG_OFF_WAIT);

  // serial/timer control: every bit plain read/write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_timer_control_r <= `SBG_RST_STC;
    end else if (wr_stc) begin
      serial_timer_control_r <= reg_wdata;
    end
  end

  // reload value N, full 8-bit range
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_rate_reload_r <= `SBG_RST_RELOAD;
    end else if (wr_reload) begin
      bit_rate_reload_r <= reg_wdata[7:0];
    end
  end

  // serial mode: selector, format bit and synchronous clock enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_mode_reg_r <= `SBG_RST_MODE;
    end else if (wr_mode) begin
      serial_mode_reg_r <= reg_wdata;
    end
  end

  // wait-state control: doubling bit and peripheral clock ratio
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_state_ctrl_reg_r <= `SBG_RST_WAIT;
    end else if (wr_wait) begin
      wait_state_ctrl_reg_r <= reg_wdata;
    end
  end

  // field extraction
  assign prescale_sel = {serial_mode_reg_r[`SBG_MODE_SEL_HI], serial_mode_reg_r[`SBG_MODE_SEL_LO]};
  assign multiproc_format_bit = serial_mode_reg_r[`SBG_MODE_MP];
  assign sync_en = serial_mode_reg_r[`SBG_MODE_SYNC];
  assign clock_double_sel = wait_state_ctrl_reg_r[`SBG_WAIT_DBL];
  assign periph_half = wait_state_ctrl_reg_r[`SBG_WAIT_PHALF];

  // this setting gives a bit every four cycles, too fast to reload data in time
  assign no_continuous = (prescale_sel == 2'h0) && (bit_rate_reload_r == 8'h00);

  // peripheral clock as an enable: every cycle, or every other when halved
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pclk_phase_r <= 1'b0;
    end else begin
      pclk_phase_r <= ~pclk_phase_r;
    end
  end
  assign pclk_en = periph_half ? pclk_phase_r : 1'b1;

  // source is the system clock for selector zero, else the peripheral clock
  assign base_en = (prescale_sel == 2'h0) ? 1'b1 : pclk_en;

  // run control: arm one cycle to realign prescaler and divider
  always_comb begin
    run_nxt = run_r;
    case (run_r)
      run_idle: begin
        if (sync_en) begin
          run_nxt = run_arm;
        end
      end
      run_arm: begin
        run_nxt = sync_en ? run_active : run_idle;
      end
      run_active: begin
        if (!sync_en) begin
          run_nxt = run_idle;
        end
      end
      default: run_nxt = run_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r <= run_idle;
    end else begin
      run_r <= run_nxt;
    end
  end

  // a new N or a new selection restarts the bit period cleanly
  assign restart = (run_r != run_active) || wr_reload || wr_mode || wr_wait;
  assign prescale_clr = restart;

  sbg_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .clr(prescale_clr),
    .base_en(base_en),
    .sel(prescale_sel),
    .dbl(clock_double_sel),
    .tick(pre_tick)
  );

  sbg_divider #(
    .RELOAD_W(8)
  ) u_divider (
    .clk(clk),
    .rst(rst),
    .restart(restart),
    .tick(pre_tick),
    .reload(bit_rate_reload_r),
    .tc(div_tc),
    .count(div_count)
  );

  // two terminal counts per half period: bit period is 4*(N+1) prescaled ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_r <= 1'b0;
      sclk_r <= 1'b1;
    end else if (restart) begin
      half_r <= 1'b0;
      sclk_r <= 1'b1; // idle high between transfers
    end else if (div_tc) begin
      half_r <= ~half_r;
      if (half_r) begin
        sclk_r <= ~sclk_r;
      end
    end
  end

  // pin drive and timing pulses, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_out <= 1'b1;
      sclk_oe <= 1'b0;
      bit_shift <= 1'b0;
      bit_sample <= 1'b0;
    end else begin
      sclk_out <= sclk_r;
      sclk_oe <= sync_en;
      // falling edge shifts out, rising edge samples in
      bit_shift <= div_tc && half_r && sclk_r && !restart;
      bit_sample <= div_tc && half_r && !sclk_r && !restart;
    end
  end

  // per-channel multiprocessor gating
  assign mp_bits = {ch1_multiproc_format_bit, multiproc_format_bit};

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_mp
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          multiproc_enable[ch] <= 1'b0;
          multiproc_active[ch] <= 1'b0;
        end else begin
          multiproc_enable[ch] <= serial_timer_control_r[`SBG_STC_MPE];
          // enable clear overrides the format bit
          multiproc_active[ch] <= serial_timer_control_r[`SBG_STC_MPE] && mp_bits[ch];
        end
      end
    end
  endgenerate

  // forwarded control fields come straight from the control register flops
  assign twowire_ctrl = serial_timer_control_r[`SBG_STC_TWOWIRE_HI:`SBG_STC_TWOWIRE_LO];
  assign host_input_switch = serial_timer_control_r[`SBG_STC_HOST_SW];
  assign timer_clk_sel = serial_timer_control_r[`SBG_STC_TMR_HI:`SBG_STC_TMR_LO];

  // read mux; unmapped addresses read zero
  always_comb begin
    reg_rdata_nxt = `SBG_RD_ZERO;
    case (reg_addr)
      `SBG_OFF_STC: reg_rdata_nxt = serial_timer_control_r;
      `SBG_OFF_RELOAD: reg_rdata_nxt = bit_rate_reload_r;
      `SBG_OFF_MODE: reg_rdata_nxt = serial_mode_reg_r;
      `SBG_OFF_WAIT: reg_rdata_nxt = wait_state_ctrl_reg_r;
      `SBG_OFF_STATUS: begin
        reg_rdata_nxt[`SBG_ST_SCLK] = sclk_r;
        reg_rdata_nxt[`SBG_ST_NOCONT] = no_continuous;
        reg_rdata_nxt[`SBG_ST_RUN] = (run_r == run_active);
      end
      `SBG_OFF_COUNT: reg_rdata_nxt = div_count;
      default: reg_rdata_nxt = `SBG_RD_ZERO;
    endcase
  end

  // read data stands the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `SBG_RD_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_nxt;
    end else begin
      reg_rdata <= `SBG_RD_ZERO;
    end
  end
endmodule // sbg_top

// File: tb/sbg_checker_assertions.sv
`timescale 1ns/100ps
module sbg_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // serial clock and pulses
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic bit_shift,
  input wire logic bit_sample,
  // forwarded fields
  input wire logic [1:0] multiproc_enable,
  input wire logic [1:0] multiproc_active,
  input wire logic [3:0] twowire_ctrl,
  input wire logic host_input_switch,
  input wire logic [1:0] timer_clk_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_twowire_fwd: assert property (reg_wr && reg_addr == 3'h0 |=> twowire_ctrl == $past(reg_wdata[7:4]))
    else $error("two-wire field not forwarded");
  a_host_fwd: assert property (reg_wr && reg_addr == 3'h0 |=> host_input_switch == $past(reg_wdata[3]))
    else $error("host switch not forwarded");
  a_timer_fwd: assert property (reg_wr && reg_addr == 3'h0 |=> timer_clk_sel == $past(reg_wdata[1:0]))
    else $error("timer select not forwarded");
  a_stc_readback: assert property (reg_rd && reg_addr == 3'h0 |=>
    reg_rdata[7:3] == {twowire_ctrl, host_input_switch} && reg_rdata[1:0] == timer_clk_sel)
    else $error("control readback differs from fields");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_mp_gate: assert property (multiproc_enable[0] == multiproc_enable[1] && (multiproc_active & ~multiproc_enable) == 2'h0)
    else $error("multiprocessor gating broken");
  a_sclk_idle: assert property (!sclk_oe [*2] |-> sclk_out && !bit_shift && !bit_sample)
    else $error("serial clock active while stopped");
  a_shift_edge: assert property ($fell(sclk_out) == $past(bit_shift))
    else $error("shift pulse not on falling clock");
  a_sample_edge: assert property (bit_sample |=> $rose(sclk_out))
    else $error("sample pulse not on rising clock");
  a_bit_spacing: assert property (bit_shift |=> !bit_shift [*3])
    else $error("bit period shorter than four clocks");
endmodule // sbg_checker
bind sbg_top sbg_checker chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .bit_shift(bit_shift),
  .bit_sample(bit_sample), .multiproc_enable(multiproc_enable), .multiproc_active(multiproc_active),
  .twowire_ctrl(twowire_ctrl), .host_input_switch(host_input_switch), .timer_clk_sel(timer_clk_sel));

// File: tb/sbg_far_dev.sv
`timescale 1ns/100ps
module sbg_far_dev (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial clock pin as seen on the wire
  input wire logic sclk,
  // measured bit period in system clocks
  output int period,
  output int falls
);
  logic sclk_q;
  int since;
  // counts each falling edge; one period only, it never relies on back-to-back frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b1;
      since <= 0;
      period <= 0;
      falls <= 0;
    end else begin
      sclk_q <= sclk;
      since <= since + 1;
      if (sclk_q && !sclk) begin
        period <= since;
        since <= 1;
        falls <= falls + 1;
      end
    end
  end
endmodule // sbg_far_dev

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ch1_fmt = 1'b0;
  logic [7:0] reg_rdata;
  logic sclk_out, sclk_oe, bit_shift, bit_sample, host_sw, sclk_pin;
  logic [1:0] mp_en, mp_act, tmr_sel;
  logic [3:0] tw_ctrl;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int far_period, far_falls;
  // released pin is pulled high
  assign sclk_pin = sclk_oe ? sclk_out : 1'b1;
  always #5 clk = ~clk;
  sbg_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ch1_multiproc_format_bit(ch1_fmt), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .bit_shift(bit_shift), .bit_sample(bit_sample), .multiproc_enable(mp_en), .multiproc_active(mp_act),
    .twowire_ctrl(tw_ctrl), .host_input_switch(host_sw), .timer_clk_sel(tmr_sel));
  sbg_far_dev far_u (.clk(clk), .rst(rst), .sclk(sclk_pin), .period(far_period), .falls(far_falls));
  task automatic summarize();
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard, far above the longest run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      failures++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic t_control();
    logic [7:0] v, d;
    rd(3'h0, v);
    chk8(v, 8'h00, "control reset");
    for (int i = 0; i < 2; i++) begin
      d = (i == 1) ? 8'h5A : 8'hA5;
      wr(3'h0, d);
      rd(3'h0, v);
      chk8(v, d, "control rw");
      chk8({4'h0, tw_ctrl}, {4'h0, d[7:4]}, "two-wire");
      chk8({7'h00, host_sw}, {7'h00, d[3]}, "host");
      chk8({6'h00, tmr_sel}, {6'h00, d[1:0]}, "timer");
      chk8({6'h00, mp_en}, {6'h00, d[2], d[2]}, "mp enable");
    end
    wr(3'h6, 8'hFF);
    rd(3'h6, v);
    chk8(v, 8'h00, "unmapped read");
    rd(3'h0, v);
    chk8(v, 8'h5A, "unmapped write leak");
  endtask
  task automatic t_multiproc();
    wr(3'h2, 8'h04);
    ch1_fmt <= 1'b1;
    wr(3'h0, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk8({6'h00, mp_act}, 8'h00, "mp gated");
    wr(3'h0, 8'h04);
    repeat (2) @(posedge clk);
    #1 chk8({4'h0, mp_en, mp_act}, 8'h0F, "mp on");
    ch1_fmt <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk8({6'h00, mp_act}, 8'h01, "mp ch1 off");
    wr(3'h0, 8'h00);
  endtask
  task automatic t_reload(input logic [7:0] n_val);
    logic [7:0] v;
    wr(3'h1, n_val);
    rd(3'h1, v);
    chk8(v, n_val, "reload");
    // while stopped the divider sits loaded with N
    rd(3'h5, v);
    chk8(v, n_val, "divider load");
  endtask
  // one period only at n=0 N=0, where back-to-back transfer is not offered
  task automatic t_rate(input int n, input int dbl, input int ph, input int nv);
    int f0, k, exp;
    logic [7:0] v;
    exp = 4 * (nv + 1) * (n == 0 ? 1 : (dbl ? 8 : 4) << (2 * (n - 1))) * ((ph && n != 0) ? 2 : 1);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'(ph * 2 + dbl));
    wr(3'h1, 8'(nv));
    f0 = far_falls;
    wr(3'h2, 8'(8'h80 + n));
    for (k = 0; k < 4000 && far_falls < f0 + 2; k++) @(negedge clk);
    chk8({7'h00, sclk_oe}, 8'h01, "clock pin enable");
    chk_int(far_falls - f0, 2, "serial clock falls");
    chk_int(far_period, exp, "bit period");
    // running flag set; no-continuous flag only for selector zero with N zero
    rd(3'h4, v);
    chk8(v & 8'h06, (n == 0 && nv == 0) ? 8'h06 : 8'h04, "status");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_control();
    t_multiproc();
    t_reload(8'h00);
    t_reload(8'hFF);
    for (int n = 0; n < 4; n++) begin
      t_rate(n, 0, 0, n == 2 ? 1 : 0);
      t_rate(n, 1, 0, n == 1 ? 2 : 0);
    end
    t_rate(0, 0, 1, 3);
    t_rate(1, 0, 1, 0);
    wr(3'h2, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk8({6'h00, sclk_oe, sclk_out}, 8'h01, "clock stopped");
    summarize();
  end
endmodule // testbench
